// ===== ilr_regs.svh
// constants and reset values for the interleaved resonant pwm block
`ifndef ILR_REGS_SVH
`define ILR_REGS_SVH
`define ILR_CLK_NS 100
`define ILR_PERIOD_NS 4000
`define ILR_PERIOD_RST (16'((`ILR_PERIOD_NS) / (`ILR_CLK_NS)))
`define ILR_PERIOD_MIN_ABS 16'h0004
`define ILR_DEAD_RST 16'h0001
`define ILR_DUTY_FULL 9'h100
`define ILR_DUTY_SHIFT 8
`endif

// ===== ilr_pkg.sv
// types shared by the interleaved resonant pwm block
package ilr_pkg;
    typedef struct packed {
        logic hbHigh;
        logic hbLow;
        logic srA;
        logic srB;
    } ilr_drive_t;
    typedef enum logic {ILR_NORMAL, ILR_HYBRID} ilr_mode_t;
endpackage

// ===== ilr_pwm.sv
// interleaved variable-frequency pwm with dead-time, trim and hybrid duty
`timescale 1ns/10ps
`include "ilr_regs.svh"
module ilr_pwm #(
    parameter int NPH = 2
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [15:0] periodIn,
    input wire logic [15:0] periodMin,
    input wire logic [15:0] deadIn,
    input wire logic [NPH-1:0][8:0] dutyTrim,
    input wire logic [8:0] hybridDuty,
    input wire logic [15:0] voltExcess,
    input wire logic [15:0] hybridLimit,
    output ilr_pkg::ilr_drive_t [NPH-1:0] drive,
    output logic hybridActive
);
    import ilr_pkg::*;

    logic [15:0] cnt_q;
    logic [15:0] per_q;
    logic [15:0] dead_q;
    logic [15:0] perSafe;
    logic boundary;
    ilr_mode_t mode_q;
    ilr_drive_t [NPH-1:0] drive_q;

    // tiny periods would leave no room for two dead-times
    always_comb
    begin
        if (periodIn < `ILR_PERIOD_MIN_ABS)
        begin
            perSafe = `ILR_PERIOD_MIN_ABS;
        end
        else
        begin
            perSafe = periodIn;
        end
    end

    // last count of the master period; while run is high, every setting moves here and nowhere else
    assign boundary = (cnt_q == per_q - 16'h0001);

    // master timebase; period follows the voltage loop
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cnt_q <= 16'h0000;
            per_q <= `ILR_PERIOD_RST;
            dead_q <= `ILR_DEAD_RST;
        end
        else if (!run)
        begin
            cnt_q <= 16'h0000;
            per_q <= perSafe;
            dead_q <= deadIn;
        end
        else if (boundary)
        begin
            cnt_q <= 16'h0000;
            per_q <= perSafe;
            dead_q <= deadIn;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // hybrid duty mode; decided once per period so duty never jumps mid pulse
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            mode_q <= ILR_NORMAL;
        end
        else if (!run)
        begin
            mode_q <= ILR_NORMAL;
        end
        else if (boundary)
        begin
            case (mode_q)
                ILR_NORMAL:
                begin
                    if (per_q <= periodMin && voltExcess > hybridLimit)
                        mode_q <= ILR_HYBRID;
                end
                ILR_HYBRID:
                begin
                    // leave once the loop pulls frequency back below maximum
                    if (per_q > periodMin)
                        mode_q <= ILR_NORMAL;
                end
                default:
                begin
                    mode_q <= ILR_NORMAL;
                end
            endcase
        end
    end

    for (genvar k = 0; k < NPH; k++)
    begin : g_phase
        logic [15:0] off_q;
        logic [15:0] on_q;
        logic [15:0] offNext;
        logic [15:0] half;
        logic [15:0] halfNext;
        logic [15:0] onFull;
        logic [15:0] onScaled;
        logic [15:0] onNext;
        logic [8:0] scale;
        logic [16:0] sum;
        logic [15:0] lc;
        logic [31:0] prod;
        logic [31:0] offProd;
        logic winHigh;
        logic winLow;
        logic srWinA;
        logic srWinB;

        // even spacing 1/NPH of a period between successive phases; phase k sits k/NPH of a period behind phase 0
        assign offProd = (32'(k) * 32'(perSafe)) / 32'(NPH);
        assign offNext = offProd[15:0];
        assign halfNext = perSafe >> 1;
        assign half = per_q >> 1;

        always_comb
        begin
            scale = dutyTrim[k];
            if (mode_q == ILR_HYBRID && hybridDuty < scale)
                scale = hybridDuty;
            if (scale > `ILR_DUTY_FULL)
                scale = `ILR_DUTY_FULL;
            if (deadIn < halfNext)
                onFull = halfNext - deadIn;
            else
                onFull = 16'h0000;
            prod = (32'(halfNext) * 32'(scale)) >> `ILR_DUTY_SHIFT;
            onScaled = prod[15:0];
            if (onScaled > onFull)
                onNext = onFull;
            else
                onNext = onScaled;
        end

        // settings for this phase change only with the master period or while run is low
        always_ff @(posedge ref_clk)
        begin
            if (srst)
            begin
                off_q <= 16'h0000;
                on_q <= 16'h0000;
            end
            else if (!run || boundary)
            begin
                off_q <= offNext;
                on_q <= onNext;
            end
        end

        // local count of this phase; its period ends where its trailing edge sits
        always_comb
        begin
            sum = 17'(cnt_q) + 17'(per_q) - 17'(off_q);
            if (sum >= 17'(per_q))
                lc = 16'(sum - 17'(per_q));
            else
                lc = sum[15:0];
        end

        // bridge windows; trailing edges sit at half and full local period
        always_comb
        begin
            winHigh = (lc < half) && (lc >= half - on_q);
            winLow = (lc >= half) && (lc >= per_q - on_q);
            // rectifier windows reuse the phase timebase, so they follow every retune
            srWinA = winHigh;
            srWinB = winLow;
        end

        // pulses end on the half and full local period, start moves with duty
        always_ff @(posedge ref_clk)
        begin
            if (srst)
            begin
                drive_q[k] <= '0;
            end
            else if (!run)
            begin
                // a halted bridge parks every gate low rather than mid pulse
                drive_q[k] <= '0;
            end
            else
            begin
                drive_q[k].hbHigh <= winHigh;
                drive_q[k].hbLow <= winLow;
                drive_q[k].srA <= srWinA;
                drive_q[k].srB <= srWinB;
            end
        end
    end

    assign drive = drive_q;

    // status lags the mode by one cycle; a registered pin is worth the delay
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            hybridActive <= 1'b0;
        end
        else
        begin
            hybridActive <= (mode_q == ILR_HYBRID);
        end
    end
endmodule // ilr_pwm

// ===== ilr_pwm_assertions.sv
// checker for the interleaved resonant pwm block
`timescale 1ns/10ps
module ilr_pwm_assertions #(parameter int NPH = 2) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [15:0] periodIn,
    input wire logic [15:0] periodMin,
    input wire logic [15:0] voltExcess,
    input wire logic [15:0] hybridLimit,
    input wire ilr_pkg::ilr_drive_t [NPH-1:0] drive,
    input wire logic hybridActive
);
    import ilr_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    chk_bridge_excl: assert property (!(drive[1].hbHigh && drive[1].hbLow))
        else $error("bridge overlap");
    chk_dead_gap: assert property ($rose(drive[0].hbLow) |-> !$past(drive[0].hbHigh))
        else $error("no dead gap");
    chk_sr_copy: assert property (drive[0].srA == drive[0].hbHigh)
        else $error("rectifier a off");
    chk_sr_lag_copy: assert property (drive[1].srB == drive[1].hbLow)
        else $error("rectifier b off");
    chk_sr_b_copy: assert property (drive[0].srB == drive[0].hbLow)
        else $error("rectifier b off");
    chk_sr_lag_a: assert property (drive[1].srA == drive[1].hbHigh)
        else $error("rectifier a off");
    chk_bridge_lead: assert property (!(drive[0].hbHigh && drive[0].hbLow))
        else $error("bridge overlap");
    // trailing edges stay paired whatever the duty of each phase
    chk_trail_one: assert property ($fell(drive[1].hbHigh) && $past(drive[0].hbLow)
        |-> !drive[0].hbLow) else $error("trailing edge skew");
    chk_trail_two: assert property ($fell(drive[1].hbLow) && $past(drive[0].hbHigh)
        |-> !drive[0].hbHigh) else $error("trailing edge skew");
    chk_hyb_entry: assert property ($rose(hybridActive) |->
        $past(voltExcess, 2) > $past(hybridLimit, 2) && $past(periodIn, 2) <= $past(periodMin, 2))
        else $error("bad hybrid entry");
    chk_hyb_exit: assert property ($fell(hybridActive) |->
        $past(periodIn, 2) > $past(periodMin, 2)) else $error("bad hybrid exit");
    cov_entry: cover property ($rose(hybridActive));
    cov_exit: cover property ($fell(hybridActive));
    cov_trail: cover property ($fell(drive[1].hbHigh));
endmodule // ilr_pwm_assertions
bind ilr_pwm ilr_pwm_assertions #(.NPH(NPH)) u_chk (.ref_clk(ref_clk), .srst(srst),
    .periodIn(periodIn), .periodMin(periodMin), .voltExcess(voltExcess),
    .hybridLimit(hybridLimit), .drive(drive), .hybridActive(hybridActive));

// ===== ilr_gate_model.sv
// gate driver model stamping pulse widths and phase lag
`timescale 1ns/10ps
module ilr_gate_model (
    input wire logic ref_clk,
    input wire ilr_pkg::ilr_drive_t [1:0] drive,
    output int w0,
    output int w1,
    output int lag
);
    import ilr_pkg::*;
    int cnt = 0;
    int r0, r1, f0;
    ilr_drive_t [1:0] prv = '0;
    // ideal drivers: no turn-on delay, so widths are exact cycle counts
    always @(posedge ref_clk)
    begin
        cnt <= cnt + 1;
        prv <= drive;
        if (drive[0].hbHigh && !prv[0].hbHigh)
            r0 <= cnt;
        if (drive[1].hbHigh && !prv[1].hbHigh)
            r1 <= cnt;
        if (!drive[0].hbHigh && prv[0].hbHigh)
        begin
            w0 <= cnt - r0;
            f0 <= cnt;
        end
        if (!drive[1].hbHigh && prv[1].hbHigh)
        begin
            w1 <= cnt - r1;
            lag <= cnt - f0;
        end
    end
endmodule // ilr_gate_model

// ===== tb_interleaved_resonant_pwm.sv
// testbench for the interleaved resonant pwm block
`timescale 1ns/10ps
module tb_interleaved_resonant_pwm;
    import ilr_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] periodIn = 16'h0028;
    logic [15:0] deadIn = 16'h0001;
    logic [1:0][8:0] dutyTrim = {9'h100, 9'h100};
    logic [8:0] hybridDuty = 9'h100;
    logic [15:0] voltExcess = 16'h0000;
    ilr_drive_t [1:0] drive;
    logic hybridActive;
    int w0, w1, lag, errors = 0, n_checks = 0;
    ilr_pwm #(.NPH(2)) u_dut (.ref_clk(ref_clk), .srst(srst), .run(1'b1),
        .periodIn(periodIn), .periodMin(16'h0014), .deadIn(deadIn), .dutyTrim(dutyTrim),
        .hybridDuty(hybridDuty), .voltExcess(voltExcess), .hybridLimit(16'h000A),
        .drive(drive), .hybridActive(hybridActive));
    ilr_gate_model u_gate (.ref_clk(ref_clk), .drive(drive), .w0(w0), .w1(w1), .lag(lag));
    initial forever #50 ref_clk = ~ref_clk;
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s exp %0d seen %0d", nm, exp, seen);
        end
    endtask
    function automatic int on_time(int p, int d, int s);
        return ((p / 2) * s) >> 8 < p / 2 - d ? ((p / 2) * s) >> 8 : p / 2 - d;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic scenario(input string nm, input int p, d, t1, h, v);
        logic hy;
        logic hi;
        int s0, s1;
        hy = p <= 20 && v > 10;
        s0 = hy ? h : 256;
        s1 = hy && h < t1 ? h : t1;
        hi = 1'b0;
        @(posedge ref_clk);
        periodIn <= 16'(p);
        deadIn <= 16'(d);
        dutyTrim[1] <= 9'(t1);
        hybridDuty <= 9'(h);
        voltExcess <= 16'(v);
        // settings land only at a boundary, so let several periods pass
        repeat (200) @(posedge ref_clk);
        for (int i = 0; i < p; i++)
        begin
            @(negedge ref_clk);
            hi = hi | drive[0].hbHigh | drive[1].hbHigh;
        end
        check("hybrid", 16'(hybridActive), 16'(hy));
        check("active", 16'(hi), 16'(on_time(p, d, s0) + on_time(p, d, s1) > 0));
        if (s1 > 0)
        begin
            check("width0", 16'(w0), 16'(on_time(p, d, s0)));
            check("width1", 16'(w1), 16'(on_time(p, d, s1)));
            check("lag", 16'(lag), 16'(p / 2));
        end
        $display("test %s done", nm);
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        scenario("default", 40, 1, 256, 256, 0);
        scenario("trim", 40, 1, 128, 256, 0);
        scenario("retune", 24, 2, 128, 256, 0);
        scenario("hybrid", 16, 1, 128, 64, 50);
        scenario("burst", 16, 1, 128, 0, 50);
        scenario("exit", 40, 1, 128, 0, 50);
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end
endmodule // tb_interleaved_resonant_pwm
